// ### src/pcsr_pkg.sv
// Constants for the port configuration and stop-recovery control bank
`default_nettype none
package pcsr_pkg;
  localparam logic [3:0] BANK_EXPANDED_F  = 4'hF;
  localparam logic [7:0] ADDR_STOP_RECOV  = 8'h0B;
  localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
  localparam logic [7:0] PCFG_RESET       = 8'hFE;
  localparam logic [6:0] SRC_RESET        = 7'h20;
  localparam int         BIT_CMP_ROUTE    = 0;
  localparam int         BIT_P1_PUSHPULL  = 1;
  localparam int         BIT_P0_PUSHPULL  = 2;
  localparam int         BIT_P0_STD       = 3;
  localparam int         BIT_P1_STD       = 4;
  localparam int         BIT_P2_STD       = 5;
  localparam int         BIT_P3_STD       = 6;
  localparam int         BIT_OSC_STD      = 7;
  localparam int         BIT_DIV16        = 0;
  localparam int         BIT_DIV1         = 1;
  localparam int         BIT_SRC_LO       = 2;
  localparam int         BIT_DELAY_EN     = 5;
  localparam int         BIT_WAKE_HIGH    = 6;
  localparam int         BIT_STOP_FLAG    = 7;
  localparam logic [2:0] SRC_NONE         = 3'h0;
  localparam logic [2:0] SRC_P3L0         = 3'h1;
  localparam logic [2:0] SRC_P3L1         = 3'h2;
  localparam logic [2:0] SRC_P3L2         = 3'h3;
  localparam logic [2:0] SRC_P3L3         = 3'h4;
  localparam logic [2:0] SRC_P2L7         = 3'h5;
  localparam logic [2:0] SRC_NOR_LOW4     = 3'h6;
  localparam logic [2:0] SRC_NOR_ALL8     = 3'h7;
  localparam logic [4:0] DIV_CNT_RESET    = 5'h00;
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_STOP  = 3'h2,
    ST_WAKE  = 3'h4
  } pcsr_state_type;
endpackage
`default_nettype wire

// ### src/pcsr_wake_select.sv
// Stop-mode wake source selection and level compare
`default_nettype none
module pcsr_wake_select
  import pcsr_pkg::*;
(
  input  wire logic [2:0] srcSel,
  input  wire logic       wakeHigh,
  input  wire logic [3:0] port3Low,
  input  wire logic [7:0] port2In,
  output logic            wakeHit
);
  logic recovSig;
  always_comb begin
    case (srcSel)
      SRC_P3L0:     recovSig = port3Low[0];
      SRC_P3L1:     recovSig = port3Low[1];
      SRC_P3L2:     recovSig = port3Low[2];
      SRC_P3L3:     recovSig = port3Low[3];
      SRC_P2L7:     recovSig = port2In[7];
      SRC_NOR_LOW4: recovSig = ~|port2In[3:0];
      SRC_NOR_ALL8: recovSig = ~|port2In;
      default:      recovSig = ~wakeHigh;
    endcase
  end
  // Reset-only source never matches, since the idle value is the inactive level
  assign wakeHit = (srcSel != SRC_NONE) && (recovSig == wakeHigh);
endmodule
`default_nettype wire

// ### src/pcsr_ctrl.sv
// Port configuration and stop-recovery control registers with clock divide
// Functional notes
// - Config bit 0 high routes comparator outputs to port3 lines 4 and 7; resets 0.
// - Config bit 1 selects port 1 open-drain (0) or push-pull (1); default 1.
// - Config bit 2 selects port 0 open-drain (0) or push-pull (1); default 1.
// - Config bit 3 selects port 0 reduced-noise (0) or standard (1); default 1.
// - Config bit 4 selects port 1 reduced-noise or standard; default 1, emulator needs 1.
// - Config bit 5 selects port 2 reduced-noise or standard; default 1.
// - Config bit 6 selects port 3 reduced-noise or standard; default 1.
// - Config bit 7 picks oscillator drive; never changes system clock ratio.
// - Stop-recovery bit 7 read-only flag set by recovery, cleared by power-on.
// - Stop-recovery bit 6 selects wake level: 0 low (default), 1 high.
// - Stop-recovery bit 5 enables post-recovery reset delay; default on.
// - Stop-recovery bits 4:2 choose the wake source; default reset only.
// - Stop-recovery bit 1: 0 clocks at crystal/2, 1 at crystal rate.
// - Stop-recovery bit 0 adds divide-by-16 to system and timer clocks.
// - Stop-recovery register sits in expanded bank F at address 0BH.
// - Stop recovery keeps watchdog, stop-recovery, port2 and port3 mode registers.
`default_nettype none
module pcsr_ctrl
  import pcsr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] regBank,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regWrData,
  output logic [7:0]      regRdData,
  input  wire logic       stopReq,
  input  wire logic [3:0] port3LowPins,
  input  wire logic [7:0] port2Pins,
  output logic            stopActive,
  output logic            recoverPulse,
  output logic            recoverDelayEn,
  output logic            compRouteEn,
  output logic            port1PushPull,
  output logic            port0PushPull,
  output logic            port0StdDrive,
  output logic            port1StdDrive,
  output logic            port2StdDrive,
  output logic            port3StdDrive,
  output logic            oscStdDrive,
  output logic            clkTick
);
  logic [7:0]     pcfg_q;
  logic [6:0]     srcCtl_q;
  logic           stopFlag_q;
  logic [3:0]     p3Meta_q;
  logic [3:0]     p3Sync_q;
  logic [7:0]     p2Meta_q;
  logic [7:0]     p2Sync_q;
  logic [4:0]     divCnt_q;
  logic [4:0]     divCnt_d;
  logic           tick_q;
  logic [7:0]     rdData_q;
  logic           wakeHit;
  logic           recov_q;
  pcsr_state_type state_q;

  function automatic logic hit(input logic [3:0] bank, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (bank == BANK_EXPANDED_F) && (addr == target);
  endfunction

  // Pins are asynchronous to sys_clk, so two stages before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p3Meta_q <= 4'h0;
      p3Sync_q <= 4'h0;
      p2Meta_q <= 8'h00;
      p2Sync_q <= 8'h00;
    end else begin
      p3Meta_q <= port3LowPins;
      p3Sync_q <= p3Meta_q;
      p2Meta_q <= port2Pins;
      p2Sync_q <= p2Meta_q;
    end
  end

  // Port configuration register, write only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcfg_q <= PCFG_RESET;
    end else if (regWrEn && hit(regBank, regAddr, ADDR_PORT_CONFIG)) begin
      pcfg_q <= regWrData;
    end
  end

  // Stop-recovery control bits; only power-on reset restores them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      srcCtl_q <= SRC_RESET;
    end else if (regWrEn && hit(regBank, regAddr, ADDR_STOP_RECOV)) begin
      srcCtl_q <= regWrData[6:0];
    end
  end
  // Recovery itself never touches srcCtl_q

  pcsr_wake_select u_wake (
    .srcSel   (srcCtl_q[BIT_SRC_LO +: 3]),
    .wakeHigh (srcCtl_q[BIT_WAKE_HIGH]),
    .port3Low (p3Sync_q),
    .port2In  (p2Sync_q),
    .wakeHit  (wakeHit)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      recov_q <= 1'b0;
    end else begin
      recov_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (stopReq) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wakeHit) begin
            state_q <= ST_WAKE;
            recov_q <= 1'b1;
          end
        end
        ST_WAKE: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Flag only clears at power-on; recovery sets it and no write reaches it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stopFlag_q <= 1'b0;
    end else if (recov_q) begin
      stopFlag_q <= 1'b1;
    end
  end

  // Base divide is /2 or /1, with optional extra /16 on top
  always_comb begin
    logic [4:0] limit;
    limit = 5'h00;
    case ({srcCtl_q[BIT_DIV16], srcCtl_q[BIT_DIV1]})
      2'b00:   limit = 5'h01;
      2'b01:   limit = 5'h00;
      2'b10:   limit = 5'h1F;
      default: limit = 5'h0F;
    endcase
    if (divCnt_q >= limit) begin
      divCnt_d = DIV_CNT_RESET;
    end else begin
      divCnt_d = divCnt_q + 5'h01;
    end
  end

  // Oscillator drive bit is not an input here: the ratio cannot move with it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= DIV_CNT_RESET;
      tick_q   <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tick_q   <= (divCnt_d == DIV_CNT_RESET);
    end
  end

  // Read path: only the flag is visible, write-only bits read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRdEn && hit(regBank, regAddr, ADDR_STOP_RECOV)) begin
      rdData_q <= {stopFlag_q, 7'h00};
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData      = rdData_q;
  assign stopActive     = (state_q == ST_STOP);
  assign recoverPulse   = recov_q;
  assign recoverDelayEn = srcCtl_q[BIT_DELAY_EN];
  assign compRouteEn    = pcfg_q[BIT_CMP_ROUTE];
  assign port1PushPull  = pcfg_q[BIT_P1_PUSHPULL];
  assign port0PushPull  = pcfg_q[BIT_P0_PUSHPULL];
  assign port0StdDrive  = pcfg_q[BIT_P0_STD];
  assign port1StdDrive  = pcfg_q[BIT_P1_STD];
  assign port2StdDrive  = pcfg_q[BIT_P2_STD];
  assign port3StdDrive  = pcfg_q[BIT_P3_STD];
  assign oscStdDrive    = pcfg_q[BIT_OSC_STD];
  assign clkTick        = tick_q;
endmodule
`default_nettype wire

// ### tb/pcsr_ctrl_chk.sv
// Assertion checker for the port configuration and stop-recovery bank
`default_nettype none
module pcsr_ctrl_chk
  import pcsr_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [3:0] regBank,
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       stopActive,
  input wire logic       recoverPulse,
  input wire logic       recoverDelayEn,
  input wire logic       compRouteEn,
  input wire logic       port1PushPull,
  input wire logic       port0PushPull,
  input wire logic       port0StdDrive,
  input wire logic       port1StdDrive,
  input wire logic       port2StdDrive,
  input wire logic       port3StdDrive,
  input wire logic       oscStdDrive,
  input wire logic       clkTick
);
  logic [7:0] cfgBits;
  logic [4:0] smrQ;
  wire        cfgWr = regWrEn && regBank == BANK_EXPANDED_F && regAddr == ADDR_PORT_CONFIG;
  wire        smrWr = regWrEn && regBank == BANK_EXPANDED_F && regAddr == ADDR_STOP_RECOV;
  assign cfgBits = {oscStdDrive, port3StdDrive, port2StdDrive, port1StdDrive, port0StdDrive,
                    port0PushPull, port1PushPull, compRouteEn};
  // Shadow of source and divide bits, since the register itself cannot be read back
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) smrQ <= 5'h00;
    else if (smrWr) smrQ <= regWrData[4:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  route_bit_a: assert property (cfgWr |=> compRouteEn == $past(regWrData[0])) else $error("route bit");
  push_pull_a: assert property (cfgWr |=> cfgBits[2:1] == $past(regWrData[2:1])) else $error("drive type");
  drive_mode_a: assert property (cfgWr |=> cfgBits[7:3] == $past(regWrData[7:3])) else $error("noise mode");
  cfg_hold_a: assert property (!cfgWr |=> $stable(cfgBits)) else $error("config moved");
  delay_bit_a: assert property (smrWr |=> recoverDelayEn == $past(regWrData[5])) else $error("delay bit");
  delay_hold_a: assert property (!smrWr |=> $stable(recoverDelayEn)) else $error("delay moved");
  flag_read_a: assert property (regRdEn && regBank == BANK_EXPANDED_F && regAddr == ADDR_STOP_RECOV
    |=> regRdData[6:0] == 7'h00) else $error("write-only bits read");
  pulse_once_a: assert property (recoverPulse |=> !recoverPulse && !stopActive) else $error("wake pulse");
  no_wake_a: assert property (stopActive && smrQ[4:2] == SRC_NONE |=> !recoverPulse) else $error("wake");
  tick_full_a: assert property (smrQ[1:0] == 2'h2 && $past(smrQ[1:0]) == 2'h2 |-> clkTick)
    else $error("tick rate");
  tick_half_a: assert property (clkTick && smrQ[1:0] == 2'h0 && $past(smrQ[1:0]) == 2'h0 |=> !clkTick)
    else $error("tick gap");
endmodule
bind pcsr_ctrl pcsr_ctrl_chk pcsr_ctrl_chk_i (.sys_clk(sys_clk), .rst(rst), .regBank(regBank),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
  .stopActive(stopActive), .recoverPulse(recoverPulse), .recoverDelayEn(recoverDelayEn),
  .compRouteEn(compRouteEn), .port1PushPull(port1PushPull), .port0PushPull(port0PushPull),
  .port0StdDrive(port0StdDrive), .port1StdDrive(port1StdDrive), .port2StdDrive(port2StdDrive),
  .port3StdDrive(port3StdDrive), .oscStdDrive(oscStdDrive), .clkTick(clkTick));
`default_nettype wire

// ### tb/tb_pcsr_ctrl.sv
// Self-checking bench for the port configuration and stop-recovery bank
`default_nettype none
module tb_pcsr_ctrl
  import pcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, stopReq = 0, wrV = 0, rdV = 0;
  logic [3:0] regBank = 4'h0, port3LowPins = 4'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, port2Pins = 8'h00, regRdData, cfgOut, rdQ[$];
  logic       stopActive, recoverPulse, recoverDelayEn, clkTick;
  logic [8:0] expCfg = 9'h1FE, n, cfgQ[$];
  int         num_errors = 0, tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  pcsr_ctrl pcsr_ctrl_i (.sys_clk(sys_clk), .rst(rst), .regBank(regBank), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .stopReq(stopReq),
    .port3LowPins(port3LowPins), .port2Pins(port2Pins), .stopActive(stopActive), .recoverPulse(recoverPulse),
    .recoverDelayEn(recoverDelayEn), .compRouteEn(cfgOut[0]), .port1PushPull(cfgOut[1]),
    .port0PushPull(cfgOut[2]), .port0StdDrive(cfgOut[3]), .port1StdDrive(cfgOut[4]),
    .port2StdDrive(cfgOut[5]), .port3StdDrive(cfgOut[6]), .oscStdDrive(cfgOut[7]), .clkTick(clkTick));
  task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] b, logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    {regBank, regAddr, regWrData, regWrEn} = {b, a, d, 1'b1};
    if (b == BANK_EXPANDED_F && a == ADDR_PORT_CONFIG) expCfg[7:0] = d;
    if (b == BANK_EXPANDED_F && a == ADDR_STOP_RECOV) expCfg[8] = d[5];
    cfgQ.push_back(expCfg);
    @(negedge sys_clk);
    regWrEn = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge sys_clk);
    {regBank, regAddr, regRdEn} = {BANK_EXPANDED_F, a, 1'b1};
    rdQ.push_back(e);
    @(negedge sys_clk);
    regRdEn = 0;
  endtask
  task automatic stop();
    @(negedge sys_clk);
    stopReq = 1;
    @(negedge sys_clk);
    stopReq = 0;
    repeat (4) @(negedge sys_clk);
    chk("stop", 9'h001, {8'h00, stopActive});
  endtask
  // Window of 64 is a multiple of every divide, so the tick phase does not matter
  task automatic ticks(logic [1:0] dv, logic [8:0] e);
    wr(BANK_EXPANDED_F, ADDR_STOP_RECOV, {6'h08, dv});
    repeat (4) @(negedge sys_clk);
    n = 0;
    repeat (64) begin
      @(negedge sys_clk);
      n += clkTick;
    end
    chk("ticks", e, n);
  endtask
  task automatic wake(logic [2:0] s, logic l);
    logic v;
    v = (s >= SRC_NOR_LOW4) ? l : ~l;
    wr(BANK_EXPANDED_F, ADDR_STOP_RECOV, {1'b0, l, s[1], s, 2'h2});
    {port3LowPins, port2Pins} = {12{v}};
    stop();
    {port3LowPins, port2Pins} = {12{~v}};
    n = 0;
    repeat (12) begin
      @(negedge sys_clk);
      n += recoverPulse;
    end
    chk("wake", 9'h001, n);
    chk("delay", {8'h00, expCfg[8]}, {8'h00, recoverDelayEn});
    rd(ADDR_STOP_RECOV, 8'h80);
  endtask
  always @(posedge sys_clk) begin
    wrV <= regWrEn;
    rdV <= regRdEn;
  end
  always @(negedge sys_clk) begin
    if (wrV) chk("config", cfgQ.pop_front(), {recoverDelayEn, cfgOut});
    if (rdV) chk("read", {1'b0, rdQ.pop_front()}, {1'b0, regRdData});
  end
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hADF8));
    repeat (6) @(negedge sys_clk);
    rst = 0;
    wr(4'($urandom % 15), ADDR_PORT_CONFIG, 8'($urandom));
    wr(BANK_EXPANDED_F, 8'h55, 8'h00);
    for (int i = 0; i < 10; i++) wr(BANK_EXPANDED_F, ADDR_PORT_CONFIG, i < 2 ? {8{i[0]}} : 8'($urandom));
    rd(ADDR_PORT_CONFIG, 8'h00);
    rd(8'h55, 8'h00);
    wr(BANK_EXPANDED_F, ADDR_STOP_RECOV, 8'hC0);
    rd(ADDR_STOP_RECOV, 8'h00);
    ticks(2'h0, 9'd32);
    ticks(2'h2, 9'd64);
    ticks(2'h1, 9'd2);
    ticks(2'h3, 9'd4);
    for (int s = 1; s < 8; s++) wake(3'(s), s[0]);
    wr(BANK_EXPANDED_F, ADDR_STOP_RECOV, 8'h22);
    stop();
    {port3LowPins, port2Pins} = 12'hA5A;
    stop();
    rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    expCfg = 9'h1FE;
    rd(ADDR_STOP_RECOV, 8'h00);
    wr(4'h0, ADDR_PORT_CONFIG, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
